//--- hw/cpsba_defs.svh
/*
 * Constants of the program-flow, banking and arithmetic core: data-memory
 * offsets, status bit positions, reset values and timing counts.
 * Assumes it is included by bare name from the core and its package users.
 */
`ifndef CPSBA_DEFS_SVH
`define CPSBA_DEFS_SVH

// ****************************************************************
// data memory offsets (low seven address bits, same in both banks)
// ****************************************************************
`define CPSBA_ADDR_INDIRECT  7'h00
`define CPSBA_ADDR_PCL       7'h02
`define CPSBA_ADDR_STATUS    7'h03
`define CPSBA_ADDR_FSR       7'h04
`define CPSBA_ADDR_PC_UPPER_LATCH    7'h0a
`define CPSBA_GPR_FIRST      7'h0c

// ****************************************************************
// status bit positions
// ****************************************************************
`define CPSBA_ST_C           0
`define CPSBA_ST_DC          1
`define CPSBA_ST_Z           2
`define CPSBA_ST_PD          3
`define CPSBA_ST_TO          4
`define CPSBA_ST_BANK        5

// ****************************************************************
// masks and reset values
// ****************************************************************
`define CPSBA_STATUS_RO_MASK 8'h18
`define CPSBA_PC_UPPER_LATCH_MASK    8'h1f
`define CPSBA_STATUS_RST     8'h18
`define CPSBA_PC_UPPER_LATCH_RST     8'h00
`define CPSBA_FSR_RST        8'h00
`define CPSBA_W_RST          8'h00
`define CPSBA_PC_RST         13'h0000
`define CPSBA_INT_VECTOR     13'h0004

// ****************************************************************
// timing
// ****************************************************************
`define CPSBA_CLKS_PER_ICYC  4

`endif

//--- hw/cpsba_pkg.sv
/*
 * Types shared by the core: execution phases and arithmetic operations.
 * Assumes nothing of its surroundings.
 */
package cpsba_pkg;

    // one instruction cycle is four clock phases
    typedef enum logic [1:0] {
        PH_ADDR,
        PH_READ,
        PH_CALC,
        PH_EXEC
    } cpsba_phase_e;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_ADD,
        OP_SUB,
        OP_AND,
        OP_IOR,
        OP_XOR,
        OP_COM,
        OP_DEC,
        OP_INC,
        OP_MOV,
        OP_MOVW,
        OP_CLR,
        OP_RLF,
        OP_RRF,
        OP_SWAP,
        OP_BCF,
        OP_BSF
    } cpsba_op_e;

endpackage : cpsba_pkg

//--- hw/cpsba_ram.sv
/*
 * General purpose register storage: one write port, one read port whose
 * data come out of a register one clock after the read strobe.
 * Assumes the caller never reads and writes the same word in one clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cpsba_ram #(
    parameter int DATA_W = 8,
    parameter int DEPTH  = 128,
    parameter int ADDR_W = $clog2(DEPTH)
) (
    input  wire logic              ref_clk_i,
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              rd_en_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [DATA_W-1:0] rd_data_o
);

    if (DEPTH < 2 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
        $error("ram depth does not fit its address width");
    end

    logic [DATA_W-1:0] mem_r [DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    // contents are undefined after power-up, and the read port is not reset either
    always_ff @(posedge ref_clk_i) begin
        if (rd_en_i) begin
            rd_data_o <= mem_r[rd_addr_i];
        end
    end

endmodule : cpsba_ram

`default_nettype wire

//--- hw/cpsba_core.sv
/*
 * Program-flow and data-addressing core: arithmetic unit with flags,
 * working register, two banks that mirror all registers, special and general, indirect
 * access, 13-bit program counter, circular return stack.
 * Assumes program memory answers prog_addr_o within one instruction cycle
 * and that interrupt enable logic outside drops irq_i after irq_ack_o.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpsba_defs.svh"

module cpsba_core
    import cpsba_pkg::*;
#(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    output logic      [12:0] prog_addr_o,
    input  wire logic [13:0] prog_data_i,
    input  wire logic        irq_i,
    output logic             irq_ack_o,
    output logic             gie_set_o,
    output logic             sleep_o,
    output logic             wdt_clear_o,
    output logic      [7:0]  w_o,
    output logic      [7:0]  status_o
);

    localparam int SP_W = $clog2(STACK_DEPTH);

    // wrap-around relies on the pointer simply rolling over
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
    begin : g_bad_stack
        $error("stack depth must be a power of two");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    cpsba_phase_e      ph_r;
    logic [13:0]       instr_r;
    logic              instr_valid_r;
    logic [12:0]       pc_r;
    logic [7:0]        w_r;
    logic [7:0]        status_r;
    logic [7:0]        status_nxt;
    logic [7:0]        fsr_r;
    logic [7:0]        pc_upper_latch_r;
    logic [7:0]        eff_addr_r;
    logic [7:0]        opnd_r;
    logic [12:0]       stack_r [STACK_DEPTH];
    logic [SP_W-1:0]   sp_r;
    logic [SP_W-1:0]   sp_dec;
    logic [7:0]        ram_rdata;
    logic              irq_ack_r;
    logic              gie_set_r;
    logic              sleep_r;
    logic              wdt_clear_r;

    // ****************************************************************
    // decode
    // ****************************************************************
    cpsba_op_e   op;
    logic        use_lit;
    logic        wr_f;
    logic        wr_w;
    logic        aff_z;
    logic        aff_c;
    logic        aff_dc;
    logic        skip_zero;
    logic        bit_test;
    logic        is_call;
    logic        is_goto;
    logic        is_ret;
    logic        is_return_from_interrupt;
    logic        is_sleep;
    logic        is_clrwdt;

    always_comb begin
        op        = OP_NOP;
        use_lit   = 1'b0;
        wr_f      = 1'b0;
        wr_w      = 1'b0;
        aff_z     = 1'b0;
        aff_c     = 1'b0;
        aff_dc    = 1'b0;
        skip_zero = 1'b0;
        bit_test  = 1'b0;
        is_call   = 1'b0;
        is_goto   = 1'b0;
        is_ret    = 1'b0;
        is_return_from_interrupt = 1'b0;
        is_sleep  = 1'b0;
        is_clrwdt = 1'b0;
        case (instr_r[13:12])
            2'b00: begin
                // byte operations: bit 7 picks file or working register
                wr_f = instr_r[7];
                wr_w = ~instr_r[7];
                case (instr_r[11:8])
                    4'h0: begin
                        wr_w = 1'b0;
                        wr_f = instr_r[7];
                        if (instr_r[7]) begin
                            op = OP_MOVW;
                        end else begin
                            case (instr_r[6:0])
                                7'h08: is_ret = 1'b1;
                                7'h09: begin
                                    is_ret    = 1'b1;
                                    is_return_from_interrupt = 1'b1;
                                end
                                7'h63: is_sleep  = 1'b1;
                                7'h64: is_clrwdt = 1'b1;
                                default: op = OP_NOP;
                            endcase
                        end
                    end
                    4'h1: begin
                        op    = OP_CLR;
                        aff_z = 1'b1;
                    end
                    4'h2: begin
                        op     = OP_SUB;
                        aff_z  = 1'b1;
                        aff_c  = 1'b1;
                        aff_dc = 1'b1;
                    end
                    4'h3: begin
                        op    = OP_DEC;
                        aff_z = 1'b1;
                    end
                    4'h4: begin
                        op    = OP_IOR;
                        aff_z = 1'b1;
                    end
                    4'h5: begin
                        op    = OP_AND;
                        aff_z = 1'b1;
                    end
                    4'h6: begin
                        op    = OP_XOR;
                        aff_z = 1'b1;
                    end
                    4'h7: begin
                        op     = OP_ADD;
                        aff_z  = 1'b1;
                        aff_c  = 1'b1;
                        aff_dc = 1'b1;
                    end
                    4'h8: begin
                        op    = OP_MOV;
                        aff_z = 1'b1;
                    end
                    4'h9: begin
                        op    = OP_COM;
                        aff_z = 1'b1;
                    end
                    4'ha: begin
                        op    = OP_INC;
                        aff_z = 1'b1;
                    end
                    4'hb: begin
                        op        = OP_DEC;
                        skip_zero = 1'b1;
                    end
                    4'hc: begin
                        op    = OP_RRF;
                        aff_c = 1'b1;
                    end
                    4'hd: begin
                        op    = OP_RLF;
                        aff_c = 1'b1;
                    end
                    4'he: op = OP_SWAP;
                    4'hf: begin
                        op        = OP_INC;
                        skip_zero = 1'b1;
                    end
                    default: op = OP_NOP;
                endcase
            end
            2'b01: begin
                case (instr_r[11:10])
                    2'b00: begin
                        op   = OP_BCF;
                        wr_f = 1'b1;
                    end
                    2'b01: begin
                        op   = OP_BSF;
                        wr_f = 1'b1;
                    end
                    default: bit_test = 1'b1;
                endcase
            end
            2'b10: begin
                is_call = ~instr_r[11];
                is_goto = instr_r[11];
            end
            default: begin
                use_lit = 1'b1;
                wr_w    = 1'b1;
                case (instr_r[11:8])
                    4'h0, 4'h1, 4'h2, 4'h3: op = OP_MOV;
                    4'h4, 4'h5, 4'h6, 4'h7: begin
                        op     = OP_MOV;
                        is_ret = 1'b1;
                    end
                    4'h8: op = OP_IOR;
                    4'h9: op = OP_AND;
                    4'ha: op = OP_XOR;
                    4'hc, 4'hd: op = OP_SUB;
                    4'he, 4'hf: op = OP_ADD;
                    default: wr_w = 1'b0;
                endcase
                if (op != OP_MOV && op != OP_NOP) begin
                    aff_z = 1'b1;
                end
                if (op == OP_ADD || op == OP_SUB) begin
                    aff_c  = 1'b1;
                    aff_dc = 1'b1;
                end
            end
        endcase
    end

    // ****************************************************************
    // arithmetic unit
    // ****************************************************************
    logic [7:0] a_opnd;
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [4:0] sum5;
    logic [4:0] dif5;
    logic [7:0] bit_mask;
    logic [7:0] res;
    logic       c_out;
    logic       dc_out;

    assign a_opnd   = use_lit ? instr_r[7:0] : opnd_r;
    assign sum9     = {1'b0, a_opnd} + {1'b0, w_r};
    assign dif9     = {1'b0, a_opnd} - {1'b0, w_r};
    assign sum5     = {1'b0, a_opnd[3:0]} + {1'b0, w_r[3:0]};
    assign dif5     = {1'b0, a_opnd[3:0]} - {1'b0, w_r[3:0]};
    assign bit_mask = 8'h01 << instr_r[9:7];

    always_comb begin
        res    = a_opnd;
        c_out  = status_r[`CPSBA_ST_C];
        dc_out = status_r[`CPSBA_ST_DC];
        case (op)
            OP_ADD: begin
                res    = sum9[7:0];
                c_out  = sum9[8];
                dc_out = sum5[4];
            end
            OP_SUB: begin
                res    = dif9[7:0];
                c_out  = ~dif9[8];
                dc_out = ~dif5[4];
            end
            OP_AND:  res = a_opnd & w_r;
            OP_IOR:  res = a_opnd | w_r;
            OP_XOR:  res = a_opnd ^ w_r;
            OP_COM:  res = ~a_opnd;
            OP_DEC:  res = a_opnd - 8'h01;
            OP_INC:  res = a_opnd + 8'h01;
            OP_MOVW: res = w_r;
            OP_CLR:  res = 8'h00;
            OP_RLF: begin
                res   = {a_opnd[6:0], status_r[`CPSBA_ST_C]};
                c_out = a_opnd[7];
            end
            OP_RRF: begin
                res   = {status_r[`CPSBA_ST_C], a_opnd[7:1]};
                c_out = a_opnd[0];
            end
            OP_SWAP: res = {a_opnd[3:0], a_opnd[7:4]};
            OP_BCF:  res = a_opnd & ~bit_mask;
            OP_BSF:  res = a_opnd | bit_mask;
            default: res = a_opnd;
        endcase
    end

    // ****************************************************************
    // execution control
    // ****************************************************************
    logic        ex;
    logic        gpr_hit;
    logic        pcl_wr;
    logic        skip;
    logic        take_irq;
    logic        push;
    logic        pop;
    logic        flush;
    logic [12:0] pc_nxt;

    assign ex      = instr_valid_r && (ph_r == PH_EXEC);
    assign gpr_hit = eff_addr_r[6:0] >= `CPSBA_GPR_FIRST;
    assign pcl_wr  = wr_f && (eff_addr_r[6:0] == `CPSBA_ADDR_PCL);
    assign skip    = (skip_zero && res == 8'h00) ||
                     (bit_test && a_opnd[instr_r[9:7]] == instr_r[10]);
    assign take_irq = ex && irq_i &&
                      !(is_call || is_goto || is_ret || pcl_wr || skip);
    assign push    = (ex && is_call) || take_irq;
    assign pop     = ex && is_ret;
    assign sp_dec  = sp_r - 1'b1;
    assign flush   = take_irq || (ex && (is_call || is_goto || is_ret ||
                     pcl_wr || skip));

    always_comb begin
        pc_nxt = pc_r + 13'h0001;
        if (take_irq) begin
            pc_nxt = `CPSBA_INT_VECTOR;
        end else if (ex && (is_call || is_goto)) begin
            pc_nxt = {pc_upper_latch_r[4:3], instr_r[10:0]};
        end else if (pop) begin
            pc_nxt = stack_r[sp_dec];
        end else if (ex && pcl_wr) begin
            pc_nxt = {pc_upper_latch_r[4:0], res};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ph_r <= PH_ADDR;
        end else begin
            case (ph_r)
                PH_ADDR: ph_r <= PH_READ;
                PH_READ: ph_r <= PH_CALC;
                PH_CALC: ph_r <= PH_EXEC;
                default: ph_r <= PH_ADDR;
            endcase
        end
    end

    // fetch of the next word overlaps execution of the current one
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pc_r          <= `CPSBA_PC_RST;
            instr_r       <= 14'h0000;
            instr_valid_r <= 1'b0;
        end else if (ph_r == PH_EXEC) begin
            pc_r          <= pc_nxt;
            instr_r       <= prog_data_i;
            instr_valid_r <= ~flush;
        end
    end

    // ****************************************************************
    // return stack
    // ****************************************************************
    for (genvar gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
        always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
                stack_r[gi] <= 13'h0000;
            end else if (push && sp_r == SP_W'(gi)) begin
                stack_r[gi] <= pc_r;
            end
        end
    end

    // the pointer has no address, so software can neither see nor move it
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sp_r <= '0;
        end else if (push) begin
            sp_r <= sp_r + 1'b1;
        end else if (pop) begin
            sp_r <= sp_dec;
        end
    end

    // ****************************************************************
    // data memory access
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            eff_addr_r <= 8'h00;
        end else if (ph_r == PH_ADDR) begin
            if (instr_r[6:0] == `CPSBA_ADDR_INDIRECT) begin
                eff_addr_r <= fsr_r;
            end else begin
                eff_addr_r <= {status_r[`CPSBA_ST_BANK], instr_r[6:0]};
            end
        end
    end

    // bank bit is dropped: specials mirror and bank one reuses bank zero
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            opnd_r <= 8'h00;
        end else if (ph_r == PH_READ) begin
            case (eff_addr_r[6:0])
                `CPSBA_ADDR_PCL:    opnd_r <= pc_r[7:0];
                `CPSBA_ADDR_STATUS: opnd_r <= status_r;
                `CPSBA_ADDR_FSR:    opnd_r <= fsr_r;
                `CPSBA_ADDR_PC_UPPER_LATCH: opnd_r <= pc_upper_latch_r;
                default: opnd_r <= gpr_hit ? ram_rdata : 8'h00;
            endcase
        end
    end

    cpsba_ram #(
        .DATA_W (8),
        .DEPTH  (128)
    ) u_gpr (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (ex && wr_f && gpr_hit),
        .wr_addr_i (eff_addr_r[6:0]),
        .wr_data_i (res),
        .rd_en_i   (ph_r == PH_ADDR),
        .rd_addr_i (instr_r[6:0] == `CPSBA_ADDR_INDIRECT ? fsr_r[6:0]
                    : instr_r[6:0]),
        .rd_data_o (ram_rdata)
    );

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            w_r <= `CPSBA_W_RST;
        end else if (ex && wr_w) begin
            w_r <= res;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fsr_r <= `CPSBA_FSR_RST;
        end else if (ex && wr_f && eff_addr_r[6:0] == `CPSBA_ADDR_FSR) begin
            fsr_r <= res;
        end
    end

    // paging bits are stored but steer only call, goto and low-byte writes
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pc_upper_latch_r <= `CPSBA_PC_UPPER_LATCH_RST;
        end else if (ex && wr_f &&
                     eff_addr_r[6:0] == `CPSBA_ADDR_PC_UPPER_LATCH) begin
            pc_upper_latch_r <= res & `CPSBA_PC_UPPER_LATCH_MASK;
        end
    end

    // flag results win over a plain write of the same register
    always_comb begin
        status_nxt = status_r;
        if (ex) begin
            if (wr_f && eff_addr_r[6:0] == `CPSBA_ADDR_STATUS) begin
                status_nxt = (res & ~`CPSBA_STATUS_RO_MASK) |
                             (status_r & `CPSBA_STATUS_RO_MASK);
            end
            if (aff_z) begin
                status_nxt[`CPSBA_ST_Z] = (res == 8'h00);
            end
            if (aff_c) begin
                status_nxt[`CPSBA_ST_C] = c_out;
            end
            if (aff_dc) begin
                status_nxt[`CPSBA_ST_DC] = dc_out;
            end
            if (is_clrwdt || is_sleep) begin
                status_nxt[`CPSBA_ST_TO] = 1'b1;
                status_nxt[`CPSBA_ST_PD] = is_clrwdt;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            status_r <= `CPSBA_STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_ack_r   <= 1'b0;
            gie_set_r   <= 1'b0;
            sleep_r     <= 1'b0;
            wdt_clear_r <= 1'b0;
        end else begin
            irq_ack_r   <= take_irq;
            gie_set_r   <= ex && is_return_from_interrupt;
            sleep_r     <= ex && is_sleep;
            wdt_clear_r <= ex && is_clrwdt;
        end
    end

    assign prog_addr_o = pc_r;
    assign irq_ack_o   = irq_ack_r;
    assign gie_set_o   = gie_set_r;
    assign sleep_o     = sleep_r;
    assign wdt_clear_o = wdt_clear_r;
    assign w_o         = w_r;
    assign status_o    = status_r;

endmodule : cpsba_core

`default_nettype wire

//--- dv/cpsba_core_assertions.sv
/* Checker on the cpsba_core ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module cpsba_core_chk #(parameter int STACK_DEPTH = 8) (
    input wire logic        ref_clk_i,
    input wire logic        srst_i,
    input wire logic [12:0] prog_addr_o,
    input wire logic        irq_i,
    input wire logic        irq_ack_o,
    input wire logic        gie_set_o,
    input wire logic        sleep_o,
    input wire logic        wdt_clear_o,
    input wire logic [7:0]  w_o,
    input wire logic [7:0]  status_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // reset itself is the cause here, so it must not disable
    a_reset_clear: assert property (disable iff (1'b0) srst_i |=>
        prog_addr_o == 13'h0000 && status_o == 8'h18) else $error("rst pc");
    a_reset_w: assert property (disable iff (1'b0)
        srst_i |=> w_o == 8'h00) else $error("rst w");
    a_addr_hold: assert property ($changed(prog_addr_o) |=>
        $stable(prog_addr_o) [*3]) else $error("pc step");
    a_w_hold: assert property ($changed(w_o) |=>
        $stable(w_o) [*3]) else $error("w step");
    a_flag_hold: assert property ($changed(status_o) |=>
        $stable(status_o) [*3]) else $error("flag step");
    a_ack_gap: assert property (irq_ack_o |=>
        !irq_ack_o [*7]) else $error("ack gap");
    a_ack_vector: assert property (irq_ack_o |->
        (prog_addr_o == 13'h0004) [*4]) else $error("vector");
    a_ack_cause: assert property ($rose(irq_ack_o) |->
        $past(irq_i)) else $error("ack cause");
    a_pulse_single: assert property ((sleep_o || gie_set_o ||
        wdt_clear_o) |=> !(sleep_o || gie_set_o || wdt_clear_o))
        else $error("pulse");
    c_irq: cover property (irq_ack_o);
    c_bank: cover property ($rose(status_o[5]));
    c_page: cover property (prog_addr_o[12:11] == 2'b11);
endmodule : cpsba_core_chk
bind cpsba_core cpsba_core_chk #(.STACK_DEPTH(STACK_DEPTH)) chk_inst (
    .ref_clk_i, .srst_i, .prog_addr_o, .irq_i, .irq_ack_o, .w_o,
    .status_o, .gie_set_o, .sleep_o, .wdt_clear_o);
`default_nettype wire

//--- dv/tb.sv
/* Bench for cpsba_core: small programs from a ROM, random operands.
   Assumes the core fetches one word every four clocks. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    bad_count++; $display("MISMATCH t=%0t %h %h", $time, a, b); end end
module tb;
    logic        ref_clk_i = 0, srst_i = 1, irq_i = 0, hit = 0, irq_ack_o;
    logic        gie_set_o, sleep_o, wdt_clear_o;
    logic [11:0] pls = 12'h000;
    logic [12:0] prog_addr_o, tgt = 0;
    logic [7:0]  w_o, status_o, a, b;
    logic [13:0] rom [256];
    logic [13:0] mv [3] = '{14'h0820, 14'h0801, 14'h0803};
    logic [7:0]  ev [3] = '{8'h5a, 8'h00, 8'h38};
    int          bad_count = 0, n_compared = 0, cyc = 0;
    cpsba_core cpsba_core_inst (.ref_clk_i, .srst_i, .prog_addr_o,
        .prog_data_i(rom[prog_addr_o[7:0]]), .irq_i, .irq_ack_o,
        .gie_set_o, .sleep_o, .wdt_clear_o, .w_o, .status_o);
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        hit <= !srst_i && (hit || prog_addr_o === tgt);
        // one nibble per pulse output: wdt clear, return-from-irq, sleep
        pls <= srst_i ? 12'h000 :
               pls + {3'h0, wdt_clear_o, 3'h0, gie_set_o, 3'h0, sleep_o};
        // core has no enable of its own, so drop the request on ack
        if (irq_ack_o) irq_i <= 1'b0;
        if (cyc == 6000) begin
            bad_count++;
            end_of_test;
        end
    end
    // {z, dc, c, w} for add (sub=0) or literal minus w (sub=1)
    function automatic logic [10:0] alu_exp(logic sub, logic [7:0] x, y);
        logic [7:0] k;
        logic [8:0] s;
        logic [4:0] d;
        k = sub ? ~x : x;
        s = {1'b0, y} + {1'b0, k} + 9'(sub);
        d = {1'b0, y[3:0]} + {1'b0, k[3:0]} + 5'(sub);
        return {s[7:0] == 8'h00, d[4], s[8], s[7:0]};
    endfunction : alu_exp
    task automatic run(input int n);
        @(posedge ref_clk_i);
        srst_i <= 1'b1;
        repeat (12) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : run
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    initial begin
        foreach (rom[i]) rom[i] = 14'h0000;
        void'($urandom(39));
        for (int i = 0; i < 12; i++) begin
            a = 8'($urandom);
            b = i < 2 ? a : 8'($urandom);
            {rom[0], rom[1], rom[2]} =
                {6'h30, a, i[0] ? 6'h3c : 6'h3e, b, 14'h2802};
            run(40);
            `CHK({status_o[2:0], w_o}, alu_exp(i[0], a, b))
        end
        {rom[0], rom[1], rom[2], rom[3], rom[4], rom[5], rom[6]} = {14'h3030,
            14'h0084, 14'h3077, 14'h0080, 14'h3000, 14'h0830, 14'h2806};
        run(60);
        `CHK(w_o, 8'h77)
        for (int i = 0; i < 3; i++) begin
            {rom[0], rom[1], rom[2], rom[3], rom[4]} =
                {14'h305a, 14'h00a0, 14'h1683, mv[i], 14'h2804};
            run(60);
            `CHK({status_o[5], w_o}, {1'b1, ev[i]})
        end
        tgt = 13'h0107;
        {rom[0], rom[1], rom[2], rom[3], rom[7]} =
            {14'h3001, 14'h008a, 14'h3007, 14'h0082, 14'h2807};
        run(60);
        `CHK(hit, 1'b1)
        tgt = 13'h1807;
        {rom[0], rom[2]} = {14'h3018, 14'h2807};
        run(60);
        `CHK(hit, 1'b1)
        // computed jump stays inside the first 256-word block
        {rom[0], rom[1], rom[2], rom[3], rom[4], rom[5]} = {14'h3002,
            14'h0782, 14'h30ee, 14'h30ee, 14'h3e55, 14'h2805};
        run(60);
        `CHK(w_o, 8'h57)
        for (int i = 1; i < 10; i++) rom[i] = 14'h2020;
        {rom[0], rom[10], rom[32], rom[33]} =
            {14'h3000, 14'h280a, 14'h3e01, 14'h0008};
        run(240);
        `CHK(w_o, 8'h09)
        // nine nested pushes: the ninth buries the return to main
        for (int i = 0; i < 8; i++) begin
            rom[16+3*i] = 14'h2000 | 14'(19 + 3 * i);
            {rom[17+3*i], rom[18+3*i]} = {14'h3e01, 14'h0008};
        end
        {rom[0], rom[1], rom[2], rom[40]} =
            {14'h3000, 14'h2010, 14'h2802, 14'h0008};
        run(400);
        `CHK(w_o > 8'h08, 1'b1)
        tgt = 13'h0004;
        {rom[1], rom[2], rom[4], rom[5], rom[6]} =
            {14'h0000, 14'h2801, 14'h0064, 14'h0063, 14'h0009};
        run(40);
        @(posedge ref_clk_i);
        irq_i <= 1'b1;
        repeat (60) @(posedge ref_clk_i);
        #1;
        `CHK({hit, status_o}, 9'h110)
        `CHK(pls, 12'h111)
        end_of_test;
    end
endmodule : tb
`default_nettype wire
